// file: lspc_map.vh
`ifndef LSPC_MAP_VH
`define LSPC_MAP_VH
// -----------------------------------------------------------------------
// defaults and timing
// -----------------------------------------------------------------------
`define LSPC_BAUD_SERIAL    32'd9600
`define LSPC_BAUD_NET       32'd0
`define LSPC_ACK_OFS_DEF    8'h01
`define LSPC_PAYLOAD_DEF    16'h0100
`define LSPC_CLK_HZ         32'd250000000
`define LSPC_WARMUP_MS      32'd100
`define LSPC_ACKTO_NET_MS   32'd2500
`define LSPC_NEG_LOGOUT_DUR 32'h0000_0000
`define LSPC_BITS_PER_BYTE  4'h8
`define LSPC_FRAME_BITS     4'h9
`define LSPC_FIFO_DEPTH     4
`define LSPC_FIFO_AW        2
`endif

// file: lspc_top.v
`timescale 1ns/100ps
`include "lspc_map.vh"

// -----------------------------------------------------------------------
// fifo: parameterised width and depth, valid/ready both sides
// -----------------------------------------------------------------------
module lspc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = `LSPC_FIFO_DEPTH,
	parameter AW    = `LSPC_FIFO_AW
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset needed
	reg [AW-1:0]    wr_q;            // write pointer
	reg [AW-1:0]    rd_q;            // read pointer
	reg [AW:0]      cnt_q;           // fill level
	wire            push;
	wire            pop;

	assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// storage write
	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end

	// pointers and level
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // lspc_fifo

// -----------------------------------------------------------------------
// link session port control top
// -----------------------------------------------------------------------
module lspc_top #(
	parameter [31:0] WARMUP_CYC  = (`LSPC_CLK_HZ / 32'd1000) * `LSPC_WARMUP_MS,
	parameter [31:0] ACKTO_NET_CYC = 32'd625000000, // 2500 ms at 250 MHz
	parameter [31:0] DUR_UNIT_CYC = `LSPC_CLK_HZ / 32'd1000 // logout duration unit: 1 ms
) (
	input  wire        REF_CLK_I,
	input  wire        RST_I,
	// configuration straps
	input  wire        IS_NETWORK_I,      // 1 = network_link_port, 0 = serial_link_port
	input  wire        IS_DRIVE_I,        // 1 = drive side, 0 = automation side
	// session events from the link layer (one-cycle pulses)
	input  wire        LOGIN_DONE_I,
	input  wire [31:0] NEG_BAUD_I,
	input  wire [7:0]  NEG_ACK_OFS_I,
	input  wire [15:0] NEG_PAYLOAD_I,
	input  wire        LOGOUT_DONE_I,     // logout unit received and ack sent
	input  wire [31:0] LOGOUT_DUR_I,      // duration from the logout unit, ms
	input  wire        IMPLICIT_LOGOUT_I,
	input  wire        TX_START_I,        // transmitter enters warmup
	input  wire        DISCONNECT_I,      // disconnect confirm or received
	input  wire        LOGIN_TX_ABORT_I,  // login sent with abort_exchanges_flag
	input  wire        LOGIN_RX_ABORT_I,  // login received with abort_exchanges_flag
	input  wire        RESET_ACK_I,       // ack for our device-reset unit
	input  wire        RESET_RX_I,        // reset-received indication
	input  wire        TIMEOUT_IU_I,      // network time-out unit processed
	input  wire [31:0] TIMEOUT_IU_VAL_I,  // new timeout, cycles
	// pins
	input  wire        PEER_SENSE_I,      // peer presence, high = present
	input  wire        AUTO_RESET_I,      // automation reset line
	input  wire        SER_RX_I,
	output reg         SER_TX_O,
	// transmit byte stream
	input  wire [7:0]  TX_DATA_I,
	input  wire        TX_VALID_I,
	output reg         TX_READY_O,
	// receive byte stream
	output reg  [7:0]  RX_DATA_O,
	output reg         RX_VALID_O,
	// status
	output reg  [3:0]  PORT_STATE_O,
	output reg  [1:0]  TX_STATE_O,
	output reg  [31:0] BAUD_O,
	output reg  [7:0]  ACK_OFS_O,
	output reg  [15:0] PAYLOAD_O,
	output reg  [31:0] ACK_TIMEOUT_O,
	output reg         NEXUS_LOSS_O,
	output reg         ABORT_EXCH_O,
	output reg         AER_ENABLE_O,
	output reg         LINK_IU_ALLOW_O,
	output reg         WARMUP_DONE_O
);
	// -------------------------------------------------------------------
	// states, one-hot
	// -------------------------------------------------------------------
	localparam [3:0] PS_IDLE   = 4'h1; // port_idle_state
	localparam [3:0] PS_ACTIVE = 4'h2; // port_session_active_state
	localparam [3:0] PS_CLOSED = 4'h4; // port_session_closed_state
	localparam [1:0] TS_WARM   = 2'h1; // tx_warmup_state
	localparam [1:0] TS_RUN    = 2'h2; // tx_running_state

	// -------------------------------------------------------------------
	// pin synchronisers, three flops, change when 2nd and 3rd agree
	// -------------------------------------------------------------------
	reg  [2:0] sense_s_q;    // peer sense chain
	reg  [2:0] arst_s_q;     // automation reset chain
	reg  [2:0] rxd_s_q;      // serial receive chain
	reg        sense_q;      // filtered sense
	reg        arst_q;       // filtered reset line
	reg        rxd_q;        // filtered rx level

	// stage 0 only feeds stage 1
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sense_s_q <= 3'h0;
			arst_s_q  <= 3'h0;
			rxd_s_q   <= 3'h7;
			sense_q   <= 1'b0;
			arst_q    <= 1'b0;
			rxd_q     <= 1'b1;
		end else begin
			sense_s_q <= {sense_s_q[1:0], PEER_SENSE_I};
			arst_s_q  <= {arst_s_q[1:0], AUTO_RESET_I};
			rxd_s_q   <= {rxd_s_q[1:0], SER_RX_I};
			if (sense_s_q[1] == sense_s_q[2]) begin
				sense_q <= sense_s_q[2];
			end
			if (arst_s_q[1] == arst_s_q[2]) begin
				arst_q <= arst_s_q[2];
			end
			if (rxd_s_q[1] == rxd_s_q[2]) begin
				rxd_q <= rxd_s_q[2];
			end
		end
	end

	// -------------------------------------------------------------------
	// session state machine and parameters
	// -------------------------------------------------------------------
	reg  [3:0]  ps_q;
	reg  [3:0]  ps_d;
	reg  [1:0]  ts_q;
	reg  [31:0] dur_q;       // remaining logout duration, ms
	reg  [31:0] ms_q;        // cycle count within one ms
	reg  [31:0] warm_q;      // warmup timer
	reg         arst_d1_q;   // previous filtered reset line
	reg         sense_d1_q;  // previous filtered sense
	wire        reset_rx;
	wire        sense_lost;
	wire        imp_lo;

	// on the drive side, a rising edge on the automation reset line counts as reset received
	assign reset_rx   = RESET_RX_I | (IS_DRIVE_I & arst_q & ~arst_d1_q);
	assign sense_lost = ~IS_NETWORK_I & sense_d1_q & ~sense_q;
	// in the network variant, disconnect in warmup or running makes an implicit logout
	assign imp_lo = IMPLICIT_LOGOUT_I |
		(IS_NETWORK_I & DISCONNECT_I & (ts_q != 2'h0));

	// next port state
	always @* begin
		ps_d = ps_q;
		case (ps_q)
			PS_IDLE: begin
				if (LOGIN_DONE_I) begin
					ps_d = PS_ACTIVE;
				end
			end
			PS_ACTIVE: begin
				if (imp_lo | LOGOUT_DONE_I) begin
					ps_d = PS_CLOSED;
				end
			end
			PS_CLOSED: begin
				if (dur_q == 32'h0) begin
					ps_d = PS_IDLE;
				end
			end
			default: begin
				ps_d = PS_IDLE;
			end
		endcase
	end

	// state, parameters, timers
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ps_q            <= PS_IDLE;
			ts_q            <= 2'h0;
			dur_q           <= 32'h0;
			ms_q            <= 32'h0;
			warm_q          <= 32'h0;
			arst_d1_q       <= 1'b0;
			sense_d1_q      <= 1'b0;
			PORT_STATE_O    <= PS_IDLE;
			TX_STATE_O      <= 2'h0;
			BAUD_O          <= `LSPC_BAUD_SERIAL;
			ACK_OFS_O       <= `LSPC_ACK_OFS_DEF;
			PAYLOAD_O       <= `LSPC_PAYLOAD_DEF;
			ACK_TIMEOUT_O   <= 32'h0;
			NEXUS_LOSS_O    <= 1'b0;
			ABORT_EXCH_O    <= 1'b0;
			AER_ENABLE_O    <= 1'b1;
			LINK_IU_ALLOW_O <= 1'b0;
			WARMUP_DONE_O   <= 1'b0;
		end else begin
			arst_d1_q    <= arst_q;
			sense_d1_q   <= sense_q;
			ps_q         <= ps_d;
			PORT_STATE_O <= ps_d;
			// nexus loss, one-cycle pulse
			NEXUS_LOSS_O <= LOGIN_TX_ABORT_I | LOGIN_RX_ABORT_I
				| RESET_ACK_I
				| sense_lost
				| reset_rx
				| (imp_lo & (ps_q == PS_ACTIVE));
			ABORT_EXCH_O <= 1'b0;
			// defaults held while not logged in; variant picks baud
			if ((ps_q != PS_ACTIVE) && (ps_d != PS_ACTIVE)) begin
				BAUD_O    <= IS_NETWORK_I ? `LSPC_BAUD_NET : `LSPC_BAUD_SERIAL;
				ACK_OFS_O <= `LSPC_ACK_OFS_DEF;
				PAYLOAD_O <= `LSPC_PAYLOAD_DEF;
			end
			if ((ps_q == PS_IDLE) && (ps_d == PS_ACTIVE)) begin
				BAUD_O    <= NEG_BAUD_I;
				ACK_OFS_O <= NEG_ACK_OFS_I;
				PAYLOAD_O <= NEG_PAYLOAD_I;
			end
			// logout: explicit uses carried duration, implicit uses chosen value
			if ((ps_q == PS_ACTIVE) && (ps_d == PS_CLOSED)) begin
				dur_q <= imp_lo ? `LSPC_NEG_LOGOUT_DUR : LOGOUT_DUR_I;
				ms_q  <= 32'h0;
			end else if ((ps_q == PS_CLOSED) && (dur_q != 32'h0)) begin
				if (ms_q >= DUR_UNIT_CYC - 32'h1) begin
					ms_q  <= 32'h0;
					dur_q <= dur_q - 32'h1;
				end else begin
					ms_q <= ms_q + 32'h1;
				end
			end
			// implicit logout side effects differ by device role
			if (imp_lo && (ps_q == PS_ACTIVE)) begin
				ABORT_EXCH_O <= 1'b1;
				BAUD_O    <= IS_NETWORK_I ? `LSPC_BAUD_NET : `LSPC_BAUD_SERIAL;
				ACK_OFS_O <= `LSPC_ACK_OFS_DEF;
				PAYLOAD_O <= `LSPC_PAYLOAD_DEF;
				if (IS_DRIVE_I) begin
					AER_ENABLE_O <= 1'b0;
				end
			end
			if (LOGIN_DONE_I) begin
				AER_ENABLE_O <= 1'b1;
			end
			// ack timeout: network fixed start, serial follows parameters
			if (IS_NETWORK_I) begin
				if (TIMEOUT_IU_I) begin
					ACK_TIMEOUT_O <= TIMEOUT_IU_VAL_I;
				end else if (ps_q == PS_IDLE && ps_d == PS_IDLE && ACK_TIMEOUT_O == 32'h0) begin
					ACK_TIMEOUT_O <= ACKTO_NET_CYC;
				end
			end else begin
				// simple stand-in: timeout scales with ack offset frames
				ACK_TIMEOUT_O <= {24'h0, ACK_OFS_O} * (`LSPC_CLK_HZ / 32'd1000);
			end
			// transmitter machine
			case (ts_q)
				TS_WARM: begin
					if (imp_lo) begin
						ts_q <= 2'h0;
					end else if (warm_q != 32'h0) begin
						warm_q <= warm_q - 32'h1;
					end else begin
						ts_q <= TS_RUN;
					end
				end
				TS_RUN: begin
					if (imp_lo || LOGOUT_DONE_I) begin
						ts_q <= 2'h0;
					end
				end
				default: begin
					if (TX_START_I) begin
						ts_q   <= TS_WARM;
						warm_q <= WARMUP_CYC;
					end
				end
			endcase
			TX_STATE_O      <= ts_q;
			WARMUP_DONE_O   <= (ts_q == TS_WARM) && (warm_q == 32'h0);
			LINK_IU_ALLOW_O <= (ts_q == TS_RUN);
		end
	end

	// -------------------------------------------------------------------
	// serial transmitter behind a 4-word fifo
	// -------------------------------------------------------------------
	wire [7:0]  fifo_data;
	wire        fifo_valid;
	wire        fifo_ready;
	reg  [31:0] tbit_q;      // cycles per bit
	reg  [31:0] tcnt_q;
	reg  [3:0]  tidx_q;
	reg  [8:0]  tsh_q;
	reg         tbusy_q;
	wire        tx_take;

	lspc_fifo #(.WIDTH(8), .DEPTH(`LSPC_FIFO_DEPTH), .AW(`LSPC_FIFO_AW)) u_fifo (
		.clk_i       (REF_CLK_I),
		.rst_i       (RST_I),
		.in_data_i   (TX_DATA_I),
		.in_valid_i  (TX_VALID_I & TX_READY_O),
		.in_ready_o  (fifo_ready),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (tx_take)
	);

	// drain only when link units may go out; warmup stalls the fifo
	assign tx_take = fifo_valid & ~tbusy_q & LINK_IU_ALLOW_O;

	// 8n1 nrz, lsb first
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tbit_q     <= 32'h1;
			tcnt_q     <= 32'h0;
			tidx_q     <= 4'h0;
			tsh_q      <= 9'h1ff;
			tbusy_q    <= 1'b0;
			SER_TX_O   <= 1'b1;
			TX_READY_O <= 1'b0;
		end else begin
			TX_READY_O <= fifo_ready;
			// zero baud (network) falls back to the serial default
			tbit_q <= `LSPC_CLK_HZ / ((BAUD_O == 32'h0) ? `LSPC_BAUD_SERIAL : BAUD_O);
			if (tx_take) begin
				tsh_q    <= {1'b1, fifo_data};
				SER_TX_O <= 1'b0;               // start bit
				tbusy_q  <= 1'b1;
				tcnt_q   <= 32'h0;
				tidx_q   <= 4'h0;
			end else if (tbusy_q) begin
				if (tcnt_q >= tbit_q - 32'h1) begin
					tcnt_q <= 32'h0;
					if (tidx_q == `LSPC_FRAME_BITS) begin
						tbusy_q <= 1'b0; // stop bit done
					end else begin
						SER_TX_O <= tsh_q[0];
						tsh_q    <= {1'b1, tsh_q[8:1]};
						tidx_q   <= tidx_q + 4'h1;
					end
				end else begin
					tcnt_q <= tcnt_q + 32'h1;
				end
			end
		end
	end

	// -------------------------------------------------------------------
	// serial receiver, mid-bit sampling
	// -------------------------------------------------------------------
	reg  [31:0] rcnt_q;
	reg  [3:0]  ridx_q;
	reg  [7:0]  rsh_q;
	reg         rbusy_q;

	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rcnt_q     <= 32'h0;
			ridx_q     <= 4'h0;
			rsh_q      <= 8'h0;
			rbusy_q    <= 1'b0;
			RX_DATA_O  <= 8'h0;
			RX_VALID_O <= 1'b0;
		end else begin
			RX_VALID_O <= 1'b0;
			if (!rbusy_q) begin
				if (!rxd_q) begin
					rbusy_q <= 1'b1;
					rcnt_q  <= tbit_q >> 1;
					ridx_q  <= 4'h0;
				end
			end else if (rcnt_q != 32'h0) begin
				rcnt_q <= rcnt_q - 32'h1;
			end else begin
				rcnt_q <= tbit_q - 32'h1;
				if (ridx_q == 4'h0) begin
					if (rxd_q) begin
						rbusy_q <= 1'b0; // false start
					end
					ridx_q <= 4'h1;
				end else if (ridx_q <= `LSPC_BITS_PER_BYTE) begin
					rsh_q  <= {rxd_q, rsh_q[7:1]};
					ridx_q <= ridx_q + 4'h1;
				end else begin
					rbusy_q <= 1'b0;
					if (rxd_q) begin
						RX_DATA_O  <= rsh_q; // good stop bit
						RX_VALID_O <= 1'b1;
					end
				end
			end
		end
	end
endmodule // lspc_top

// file: lspc_top_properties.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// session and transmitter checks on the top ports
// ----------------------------------------------------------------
module lspc_top_chk #(
	parameter [31:0] WARMUP_CYC = 32'd20 // warmup length in cycles
) (
	input logic        REF_CLK_I, RST_I, IS_NETWORK_I, IS_DRIVE_I,
	input logic        LOGIN_DONE_I, LOGOUT_DONE_I, IMPLICIT_LOGOUT_I,
	input logic        DISCONNECT_I, LOGIN_TX_ABORT_I, LOGIN_RX_ABORT_I,
	input logic        RESET_ACK_I, RESET_RX_I, TIMEOUT_IU_I,
	input logic [31:0] NEG_BAUD_I, TIMEOUT_IU_VAL_I, BAUD_O, ACK_TIMEOUT_O,
	input logic [7:0]  NEG_ACK_OFS_I, ACK_OFS_O,
	input logic [15:0] NEG_PAYLOAD_I, PAYLOAD_O,
	input logic [3:0]  PORT_STATE_O,
	input logic [1:0]  TX_STATE_O,
	input logic        NEXUS_LOSS_O, ABORT_EXCH_O, AER_ENABLE_O, LINK_IU_ALLOW_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	logic [31:0] wcnt_q; // cycles spent in warmup so far
	// count warmup cycles; a repetition cannot reach the real length
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) wcnt_q <= 32'h0;
		else wcnt_q <= (TX_STATE_O == 2'h1) ? wcnt_q + 32'h1 : 32'h0;
	end
	a_login_load: assert property (
		LOGIN_DONE_I && PORT_STATE_O == 4'h1 |=> PORT_STATE_O == 4'h2 &&
		BAUD_O == $past(NEG_BAUD_I) && ACK_OFS_O == $past(NEG_ACK_OFS_I) &&
		PAYLOAD_O == $past(NEG_PAYLOAD_I)) else $error("login load wrong");
	a_default_hold: assert property (
		PORT_STATE_O == 4'h1 && !LOGIN_DONE_I |=> ACK_OFS_O == 8'h01 &&
		PAYLOAD_O == 16'h0100) else $error("defaults lost before login");
	a_logout_close: assert property (
		LOGOUT_DONE_I && PORT_STATE_O == 4'h2 |=> PORT_STATE_O == 4'h4)
		else $error("logout did not close");
	a_implicit_close: assert property (
		IMPLICIT_LOGOUT_I && PORT_STATE_O == 4'h2 |=> NEXUS_LOSS_O && ABORT_EXCH_O
		##[0:3] PORT_STATE_O == 4'h1 && ACK_OFS_O == 8'h01 && PAYLOAD_O == 16'h0100)
		else $error("implicit logout handling wrong");
	a_aer_drive: assert property (
		IMPLICIT_LOGOUT_I && PORT_STATE_O == 4'h2 && IS_DRIVE_I |-> ##[1:3] !AER_ENABLE_O)
		else $error("event reporting left on");
	a_aer_auto: assert property (
		(IMPLICIT_LOGOUT_I || (IS_NETWORK_I && DISCONNECT_I)) && !IS_DRIVE_I &&
		AER_ENABLE_O |=> AER_ENABLE_O [*3])
		else $error("event reporting touched");
	a_nexus_cause: assert property (
		LOGIN_TX_ABORT_I || LOGIN_RX_ABORT_I || RESET_ACK_I || RESET_RX_I |=> NEXUS_LOSS_O)
		else $error("nexus loss missing");
	a_warmup_quiet: assert property (
		TX_STATE_O == 2'h1 |-> !LINK_IU_ALLOW_O) else $error("units allowed in warmup");
	a_warmup_len: assert property (
		TX_STATE_O == 2'h1 ##1 TX_STATE_O == 2'h2 |->
		wcnt_q + 32'h1 >= WARMUP_CYC && wcnt_q <= WARMUP_CYC + 32'h1)
		else $error("warmup length wrong");
	a_disc_logout: assert property (
		IS_NETWORK_I && DISCONNECT_I && TX_STATE_O != 2'h0 && PORT_STATE_O == 4'h2
		|-> ##[1:3] PORT_STATE_O != 4'h2) else $error("disconnect kept session");
	a_tmo_load: assert property (
		IS_NETWORK_I && TIMEOUT_IU_I |=> ACK_TIMEOUT_O == $past(TIMEOUT_IU_VAL_I))
		else $error("timeout unit not applied");
	a_tmo_keep: assert property (
		IS_NETWORK_I && !TIMEOUT_IU_I && ACK_TIMEOUT_O != 32'h0 |=> $stable(ACK_TIMEOUT_O))
		else $error("timeout changed by itself");
	c_login: cover property (LOGIN_DONE_I && PORT_STATE_O == 4'h1);
	c_implicit: cover property (IMPLICIT_LOGOUT_I && PORT_STATE_O == 4'h2);
	c_warmup: cover property (TX_STATE_O == 2'h1 ##1 TX_STATE_O == 2'h2);
	c_disc: cover property (DISCONNECT_I && IS_NETWORK_I && PORT_STATE_O == 4'h2);
endmodule // lspc_top_chk

bind lspc_top lspc_top_chk #(.WARMUP_CYC(WARMUP_CYC)) chk_u (.*);

// file: lspc_peer.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// far-side serial port: decodes our line, sends bytes back
// ----------------------------------------------------------------
module lspc_peer #(
	parameter int BIT_CYC = 10 // cycles per bit at the negotiated rate
) (
	input  wire logic clk_i,
	input  wire logic line_i, // from the port transmitter
	output logic      line_o  // towards the port receiver
);
	logic [7:0] rxq[$];   // decoded bytes in arrival order
	int         bad_stop; // frames with a low stop bit
	logic [7:0] b;        // byte being assembled
	// receiver: start edge, then mid-bit samples
	initial begin
		line_o = 1'b1; // mark level while idle
		bad_stop = 0;
		forever begin
			@(negedge line_i);
			repeat (BIT_CYC / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk_i);
				b[i] = line_i;
			end
			repeat (BIT_CYC) @(posedge clk_i);
			if (line_i !== 1'b1) bad_stop++;
			rxq.push_back(b);
		end
	end
	// transmitter: start, eight data lsb first, stop
	task send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		@(posedge clk_i);
		for (int i = 0; i < 10; i++) begin
			line_o <= f[i];
			repeat (BIT_CYC) @(posedge clk_i);
		end
	endtask
endmodule // lspc_peer

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        clk, rst, net, drv, sense, arst, tx_valid, s, got_ok;
	logic [9:0]  evt; // session pulses, one bit per event input
	logic [31:0] neg_baud, dur, tmo_val, t;
	logic [7:0]  neg_ofs, tx_data, got, e;
	logic [15:0] neg_pay;
	wire         ser_tx, ser_rx, tx_ready, rx_valid, nexus, abort_x, aer, iu_ok, wu_done;
	wire  [7:0]  rx_data, ack_ofs;
	wire  [3:0]  pstate;
	wire  [1:0]  tstate;
	wire  [31:0] baud, ack_tmo;
	wire  [15:0] payload;
	int          error_cnt, checks, n, k;
	int          cyc = 0;
	// shortened counts keep the run small
	lspc_top #(.WARMUP_CYC(32'd20), .ACKTO_NET_CYC(32'd100), .DUR_UNIT_CYC(32'd4)) dut_u (
		.REF_CLK_I(clk), .RST_I(rst), .IS_NETWORK_I(net), .IS_DRIVE_I(drv),
		.LOGIN_DONE_I(evt[0]), .NEG_BAUD_I(neg_baud), .NEG_ACK_OFS_I(neg_ofs),
		.NEG_PAYLOAD_I(neg_pay), .LOGOUT_DONE_I(evt[1]), .LOGOUT_DUR_I(dur),
		.IMPLICIT_LOGOUT_I(evt[2]), .TX_START_I(evt[3]), .DISCONNECT_I(evt[4]),
		.LOGIN_TX_ABORT_I(evt[5]), .LOGIN_RX_ABORT_I(evt[6]), .RESET_ACK_I(evt[7]),
		.RESET_RX_I(evt[8]), .TIMEOUT_IU_I(evt[9]), .TIMEOUT_IU_VAL_I(tmo_val),
		.PEER_SENSE_I(sense), .AUTO_RESET_I(arst), .SER_RX_I(ser_rx), .SER_TX_O(ser_tx),
		.TX_DATA_I(tx_data), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready),
		.RX_DATA_O(rx_data), .RX_VALID_O(rx_valid), .PORT_STATE_O(pstate),
		.TX_STATE_O(tstate), .BAUD_O(baud), .ACK_OFS_O(ack_ofs), .PAYLOAD_O(payload),
		.ACK_TIMEOUT_O(ack_tmo), .NEXUS_LOSS_O(nexus), .ABORT_EXCH_O(abort_x),
		.AER_ENABLE_O(aer), .LINK_IU_ALLOW_O(iu_ok), .WARMUP_DONE_O(wu_done));
	// 25 mbaud negotiated: ten cycles a bit
	lspc_peer #(.BIT_CYC(10)) peer_u (.clk_i(clk), .line_i(ser_tx), .line_o(ser_rx));
	// ----------------------------------------------------------------
	// clock, hang guard, shared tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up;
		end
	end
	task wrap_up;
		if (error_cnt == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one-cycle pulse; returns once the answer edge has landed
	task fire(input logic [9:0] m);
		@(negedge clk);
		evt = m;
		@(negedge clk);
		evt = 10'h0;
	endtask
	// spaced pushes: ready lags the fifo by a cycle
	task push(input logic [7:0] d);
		@(negedge clk);
		tx_data = d;
		tx_valid = 1'b1;
		@(negedge clk);
		tx_valid = 1'b0;
		@(negedge clk);
	endtask
	task watch(input int lim, output logic hit);
		hit = 1'b0;
		repeat (lim) begin
			@(negedge clk);
			if (nexus === 1'b1) hit = 1'b1;
		end
	endtask
	task reset_dut(input logic nw, input logic dr);
		net = nw;
		drv = dr;
		rst = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, net, drv, sense, arst, tx_valid, tx_data, evt} = {6'b101100, 18'h0};
		{neg_baud, neg_ofs, neg_pay} = {32'd25000000, 8'h03, 16'h0040};
		{dur, tmo_val, error_cnt, checks} = '0;
		reset_dut(1'b0, 1'b1);
		chk(baud, 32'd9600);
		chk(ack_ofs, 8'h01);
		chk(payload, 16'h0100);
		fire(10'h002);
		chk(pstate, 4'h1);
		t = ack_tmo;
		fire(10'h001);
		chk({pstate, ack_ofs, payload}, {4'h2, 8'h03, 16'h0040});
		chk(baud, 32'd25000000);
		repeat (2) @(negedge clk);
		chk(ack_tmo !== t, 1'b1);
		// fifo fills during warmup while the line stays quiet
		fire(10'h008);
		@(negedge clk);
		chk(tstate, 2'h1);
		n = 0;
		for (int i = 0; i < 6; i++) if (tx_ready === 1'b1) begin
			push(8'h5a + 8'h11 * i[7:0]);
			n++;
		end
		chk(n, 4);
		chk({ser_tx, iu_ok}, 2'b10);
		// warmup-done only stands for the last warmup cycle
		s = 1'b0;
		repeat (20) begin
			@(negedge clk);
			if (wu_done === 1'b1) s = 1'b1;
		end
		chk({tstate, s}, 3'b101);
		for (k = 0; k < 2000 && peer_u.rxq.size() < 4; k++) @(negedge clk);
		chk(peer_u.rxq.size(), 4);
		for (int i = 0; i < 4; i++) begin
			e = 8'h5a + 8'h11 * i[7:0];
			chk(peer_u.rxq[i], e);
		end
		chk(peer_u.bad_stop, 0);
		fork
			peer_u.send(8'h3c);
			begin
				for (k = 0; k < 300 && rx_valid !== 1'b1; k++) @(negedge clk);
				got = rx_data;
			end
		join
		chk(got, 8'h3c);
		dur = 32'd3;
		fire(10'h002);
		chk(pstate, 4'h4);
		repeat (9) @(negedge clk);
		chk(pstate, 4'h4);
		repeat (5) @(negedge clk);
		chk({pstate, baud}, {4'h1, 32'd9600});
		fire(10'h001);
		fire(10'h004);
		chk({nexus, abort_x}, 2'b11);
		repeat (3) @(negedge clk);
		chk({pstate, aer, ack_ofs}, {4'h1, 1'b0, 8'h01});
		for (int j = 5; j < 9; j++) begin
			fire(10'h001 << j);
			chk(nexus, 1'b1);
		end
		sense = 1'b0;
		watch(10, s);
		chk(s, 1'b1);
		arst = 1'b1;
		repeat (2) @(negedge clk);
		arst = 1'b0;
		watch(10, s);
		chk(s, 1'b1);
		// network variant, automation side
		sense = 1'b1;
		reset_dut(1'b1, 1'b0);
		chk(baud, 32'd0);
		repeat (2) @(negedge clk);
		chk(ack_tmo, 32'd100);
		fire(10'h001);
		fire(10'h008);
		fire(10'h010);
		chk({nexus, abort_x}, 2'b11);
		repeat (3) @(negedge clk);
		chk(pstate, 4'h1);
		chk({aer, ack_tmo}, {1'b1, 32'd100});
		tmo_val = 32'd77;
		fire(10'h200);
		chk(ack_tmo, 32'd77);
		wrap_up;
	end
endmodule // tb_top
